// ===== shared/dma_unit_map.vh
// dma_unit_map.vh: port offsets, field positions, reset values and timing counts
// assumes a byte-wide i/o port decoded down to four address bits
`ifndef DMA_UNIT_MAP_VH
`define DMA_UNIT_MAP_VH
// ----------------------------------------
// port offsets
// ----------------------------------------
`define OFS_INIT 4'h0
`define OFS_CHSEL 4'h1
`define OFS_CNT_LO 4'h2
`define OFS_CNT_HI 4'h3
`define OFS_ADR_LO 4'h4
`define OFS_ADR_HI 4'h5
`define OFS_ADR_UP 4'h6
`define OFS_DC_LO 4'h8
`define OFS_DC_HI 4'h9
`define OFS_MODE 4'hA
`define OFS_STATUS 4'hB
`define OFS_MASK 4'hF
// ----------------------------------------
// fields
// ----------------------------------------
`define CHSEL_BASE 2
`define DC_LO_DISABLE 2
`define DC_LO_HOLD 4
`define DC_LO_ROTATE 5
`define DC_LO_WMASK 8'h34
`define DC_HI_EXTWR 1
`define DC_HI_WMASK 8'h03
`define MODE_WMASK 8'hFD
`define MODE_DEC 5
`define MODE_AUTO 4
`define XFER_DEMAND 2'h0
`define XFER_SINGLE 2'h1
`define XFER_BLOCK 2'h2
`define DIR_VERIFY 2'h0
`define DIR_WRITE 2'h1
`define DIR_READ 2'h2
// ----------------------------------------
// reset values, timing and fifo size
// ----------------------------------------
`define RST_CHSEL 3'h0
`define RST_MODE 8'h00
`define RST_MASK 4'hF
`define RST_DC 8'h00
`define BWAIT_CLOCKS 2'h2
`define FIFO_WIDTH 28
`define FIFO_DEPTH 8
`endif

// ===== src/dma_fifo.v
// dma_fifo.v: synchronous valid/ready fifo for completed memory writes
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module dma_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock_i,
  input wire resetn_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam [AW:0] FULL_FILL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] fill;
  wire push;
  wire pop;
  assign in_ready_o = (fill != FULL_FILL);
  assign out_valid_o = (fill != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        fill <= fill + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        fill <= fill - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // dma_fifo

// ===== src/dma_priority_pick.v
// dma_priority_pick.v: picks the highest-priority pending channel
// assumes top_i names the channel that currently ranks first
`timescale 1ns/10ps
module dma_priority_pick (
  input wire [3:0] req_i,
  input wire [1:0] top_i,
  output reg [1:0] grant_o,
  output wire any_o
);
  integer k;
  reg [1:0] idx;
  reg found;
  assign any_o = |req_i;
  always @*
  begin
    grant_o = 2'h0;
    found = 1'b0;
    idx = 2'h0;
    for (k = 0; k < 4; k = k + 1)
    begin
      idx = top_i + k[1:0];
      if (!found && req_i[idx])
      begin
        grant_o = idx;
        found = 1'b1;
      end
    end
  end
endmodule // dma_priority_pick

// ===== src/dma_unit.v
// dma_unit.v: four-channel byte dma unit with port registers and bus waiting
// assumes a byte i/o port, a bus access unit granting by acknowledge,
// and a memory write sink with valid/ready
`timescale 1ns/10ps
`include "dma_unit_map.vh"
module dma_unit (
  input wire clock_i,
  input wire resetn_i,
  input wire [3:0] port_addr_i,
  input wire port_wr_i,
  input wire port_rd_i,
  input wire [7:0] port_wdata_i,
  output reg [7:0] port_rdata_o,
  input wire refresh_queue_full_i,
  input wire bus_ack_i,
  output reg bus_request_o,
  input wire [3:0] channel_request_i,
  output reg [3:0] channel_ack_o,
  input wire end_i,
  input wire ready_i,
  output reg terminal_count_o,
  output reg [19:0] mem_addr_o,
  output reg mem_read_strobe_o,
  output reg io_read_strobe_o,
  output reg io_write_strobe_o,
  input wire [7:0] io_data_i,
  output reg mem_wvalid_o,
  input wire mem_wready_i,
  output reg [19:0] mem_waddr_o,
  output reg [7:0] mem_wdata_o
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_REQ = 3'h1;
  localparam S_T1 = 3'h2;
  localparam S_T2 = 3'h3;
  localparam S_T3 = 3'h4;
  localparam S_TW = 3'h5;
  localparam S_T4 = 3'h6;
  localparam S_WAIT = 3'h7;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [15:0] base_count [0:3];
  reg [15:0] current_count [0:3];
  reg [19:0] base_address [0:3];
  reg [19:0] current_address [0:3];
  reg [7:0] channel_mode [0:3];
  reg [1:0] sel_ch;
  reg base_only;
  reg [7:0] dc_low;
  reg [7:0] dc_high;
  reg [3:0] channel_mask;
  reg [3:0] terminal_flags;
  reg [2:0] state;
  reg [1:0] cur_ch;
  reg [1:0] last_ch;
  reg end_seen;
  reg bw_flag;
  reg [1:0] bw_cnt;
  reg [2:0] next_state;
  reg [1:0] next_ch;
  reg next_req;
  reg [7:0] rd_mux;
  reg [3:0] pick_req;
  reg done;
  integer i;
  wire init;
  wire [3:0] pending;
  wire [1:0] grant;
  wire any_req;
  wire [7:0] cmode;
  wire [7:0] nmode;
  wire [15:0] ccount;
  wire [19:0] caddr;
  wire tc_hit;
  wire term;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [27:0] fifo_out_data;
  wire fifo_pop;
  wire push_now;
  wire rd_cycle;
  wire wr_cycle;
  // ----------------------------------------
  // shared decode
  // ----------------------------------------
  assign init = !resetn_i || (port_wr_i && port_addr_i == `OFS_INIT);
  assign pending = channel_request_i & ~channel_mask;
  assign cmode = channel_mode[cur_ch];
  assign nmode = channel_mode[next_ch];
  assign ccount = current_count[cur_ch];
  assign caddr = current_address[cur_ch];
  assign tc_hit = (ccount == 16'h0000);
  assign term = tc_hit || end_seen || end_i;
  assign push_now = (state == S_T4) && (cmode[3:2] == `DIR_WRITE);
  assign fifo_pop = fifo_out_valid && (!mem_wvalid_o || mem_wready_i);
  dma_priority_pick u_pick (
    .req_i(pick_req),
    .top_i(dc_low[`DC_LO_ROTATE] ? last_ch + 2'h1 : 2'h0),
    .grant_o(grant),
    .any_o(any_req)
  );
  // a full fifo stalls the next write transfer in t1, so a push never meets a full fifo
  dma_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clock_i(clock_i),
    .resetn_i(!init), // soft reset also flushes queued writes
    .in_valid_i(push_now),
    .in_ready_o(fifo_in_ready),
    .in_data_i({mem_addr_o, io_data_i}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );
  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    next_ch = cur_ch;
    done = 1'b0;
    pick_req = pending;
    case (state)
      S_IDLE:
      begin
        if (!dc_low[`DC_LO_DISABLE] && any_req)
        begin
          next_state = S_REQ;
          next_ch = grant;
        end
      end
      S_REQ:
      begin
        if (dc_low[`DC_LO_DISABLE])
          next_state = S_IDLE;
        else if (bus_ack_i)
          next_state = S_T1;
      end
      S_T1:
      begin
        if (bw_flag && !bus_ack_i)
          next_state = S_WAIT;
        else if (cmode[3:2] != `DIR_WRITE || fifo_in_ready)
          next_state = S_T2;
      end
      S_T2:
        next_state = S_T3;
      S_T3:
        next_state = ready_i ? S_T4 : S_TW;
      S_TW:
        next_state = ready_i ? S_T4 : S_TW;
      S_T4:
      begin
        done = term || cmode[7:6] == `XFER_SINGLE ||
          (cmode[7:6] == `XFER_DEMAND && !channel_request_i[cur_ch]);
        if (done)
          pick_req = pending & ~(4'h1 << cur_ch);
        if (!done)
          next_state = S_T1;
        else if (dc_low[`DC_LO_HOLD] && any_req && !dc_low[`DC_LO_DISABLE])
        begin
          next_state = S_T1;
          next_ch = grant;
        end
        else
          next_state = S_IDLE;
      end
      S_WAIT:
      begin
        if (bw_cnt == 2'h0 && bus_request_o && bus_ack_i)
          next_state = S_T1;
      end
      default:
        next_state = S_IDLE;
    endcase
    next_req = (next_state != S_IDLE) && (next_state != S_WAIT);
    if (next_state == S_WAIT && state == S_WAIT && bw_cnt <= 2'h1)
      next_req = 1'b1;
  end
  assign rd_cycle = (next_state == S_T2) || (next_state == S_T3) || (next_state == S_TW);
  assign wr_cycle = dc_high[`DC_HI_EXTWR] ? rd_cycle :
    ((next_state == S_T3) || (next_state == S_TW));
  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always @*
  begin
    rd_mux = 8'h00;
    case (port_addr_i)
      `OFS_CHSEL: rd_mux = {3'h0, base_only, 4'h1 << sel_ch};
      `OFS_CNT_LO: rd_mux = base_only ? base_count[sel_ch][7:0] :
        current_count[sel_ch][7:0];
      `OFS_CNT_HI: rd_mux = base_only ? base_count[sel_ch][15:8] :
        current_count[sel_ch][15:8];
      `OFS_ADR_LO: rd_mux = base_only ? base_address[sel_ch][7:0] :
        current_address[sel_ch][7:0];
      `OFS_ADR_HI: rd_mux = base_only ? base_address[sel_ch][15:8] :
        current_address[sel_ch][15:8];
      `OFS_ADR_UP: rd_mux = {4'h0, base_only ? base_address[sel_ch][19:16] :
        current_address[sel_ch][19:16]};
      `OFS_DC_LO: rd_mux = dc_low;
      `OFS_DC_HI: rd_mux = dc_high;
      `OFS_MODE: rd_mux = channel_mode[sel_ch];
      `OFS_STATUS: rd_mux = {channel_request_i, terminal_flags};
      `OFS_MASK: rd_mux = {4'h0, channel_mask};
      default: rd_mux = 8'h00;
    endcase
  end
  // ----------------------------------------
  // registers and datapath
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    if (init)
    begin
      // same state for pin reset and the initialize command
      for (i = 0; i < 4; i = i + 1)
      begin
        channel_mode[i] <= `RST_MODE;
        base_count[i] <= 16'h0000;
        current_count[i] <= 16'h0000;
        base_address[i] <= 20'h00000;
        current_address[i] <= 20'h00000;
      end
      {base_only, sel_ch} <= `RST_CHSEL;
      channel_mask <= `RST_MASK;
      terminal_flags <= 4'h0;
      dc_low <= `RST_DC;
      dc_high <= `RST_DC;
      state <= S_IDLE;
      cur_ch <= 2'h0;
      last_ch <= 2'h3;
      end_seen <= 1'b0;
      bw_flag <= 1'b0;
      bw_cnt <= 2'h0;
      port_rdata_o <= 8'h00;
      bus_request_o <= 1'b0;
      channel_ack_o <= 4'h0;
      terminal_count_o <= 1'b0;
      mem_addr_o <= 20'h00000;
      mem_read_strobe_o <= 1'b0;
      io_read_strobe_o <= 1'b0;
      io_write_strobe_o <= 1'b0;
      mem_wvalid_o <= 1'b0;
      mem_waddr_o <= 20'h00000;
      mem_wdata_o <= 8'h00;
    end
    else
    begin
      if (port_rd_i)
        port_rdata_o <= rd_mux;
      if (port_rd_i && port_addr_i == `OFS_STATUS)
        terminal_flags <= 4'h0;
      if (port_wr_i)
      begin
        case (port_addr_i)
          `OFS_CHSEL:
          begin
            sel_ch <= port_wdata_i[1:0];
            base_only <= port_wdata_i[`CHSEL_BASE];
          end
          `OFS_CNT_LO:
          begin
            base_count[sel_ch][7:0] <= port_wdata_i;
            if (!base_only)
              current_count[sel_ch][7:0] <= port_wdata_i;
          end
          `OFS_CNT_HI:
          begin
            base_count[sel_ch][15:8] <= port_wdata_i;
            if (!base_only)
              current_count[sel_ch][15:8] <= port_wdata_i;
          end
          `OFS_ADR_LO:
          begin
            base_address[sel_ch][7:0] <= port_wdata_i;
            if (!base_only)
              current_address[sel_ch][7:0] <= port_wdata_i;
          end
          `OFS_ADR_HI:
          begin
            base_address[sel_ch][15:8] <= port_wdata_i;
            if (!base_only)
              current_address[sel_ch][15:8] <= port_wdata_i;
          end
          `OFS_ADR_UP:
          begin
            base_address[sel_ch][19:16] <= port_wdata_i[3:0];
            if (!base_only)
              current_address[sel_ch][19:16] <= port_wdata_i[3:0];
          end
          `OFS_DC_LO: dc_low <= port_wdata_i & `DC_LO_WMASK;
          `OFS_DC_HI: dc_high <= port_wdata_i & `DC_HI_WMASK;
          `OFS_MODE: channel_mode[sel_ch] <= port_wdata_i & `MODE_WMASK;
          `OFS_MASK: channel_mask <= port_wdata_i[3:0];
          default: ;
        endcase
      end
      // hardware updates come last so they win over a colliding port write
      if (state != S_IDLE && refresh_queue_full_i)
        bw_flag <= 1'b1;
      else if (state == S_WAIT && next_state == S_T1)
        bw_flag <= 1'b0;
      else if (next_state == S_IDLE)
        bw_flag <= 1'b0;
      if (state == S_T1 && next_state == S_WAIT)
        bw_cnt <= `BWAIT_CLOCKS;
      else if (state == S_WAIT && bw_cnt != 2'h0)
        bw_cnt <= bw_cnt - 2'h1;
      if (end_i && state != S_IDLE)
        end_seen <= 1'b1;
      terminal_count_o <= 1'b0;
      if (state == S_T4)
      begin
        if (cmode[`MODE_DEC])
          current_address[cur_ch] <= caddr - 20'h00001;
        else
          current_address[cur_ch] <= caddr + 20'h00001;
        current_count[cur_ch] <= ccount - 16'h0001;
        terminal_count_o <= tc_hit;
        if (term)
        begin
          terminal_flags[cur_ch] <= 1'b1;
          end_seen <= 1'b0;
          if (cmode[`MODE_AUTO])
          begin
            current_count[cur_ch] <= base_count[cur_ch];
            current_address[cur_ch] <= base_address[cur_ch];
          end
          else
            channel_mask[cur_ch] <= 1'b1;
        end
        if (done)
          last_ch <= cur_ch;
      end
      state <= next_state;
      cur_ch <= next_ch;
      bus_request_o <= next_req;
      channel_ack_o <= 4'h0;
      if (next_state != S_IDLE && next_state != S_REQ && next_state != S_WAIT)
        channel_ack_o <= 4'h1 << next_ch;
      if (next_state == S_T1 && state != S_WAIT)
        mem_addr_o <= current_address[next_ch];
      if (next_state == S_T1 && state == S_T4 && !done)
        mem_addr_o <= cmode[`MODE_DEC] ? caddr - 20'h00001 : caddr + 20'h00001;
      // verify cycles keep every strobe low
      mem_read_strobe_o <= (nmode[3:2] == `DIR_READ) && rd_cycle;
      io_write_strobe_o <= (nmode[3:2] == `DIR_READ) && wr_cycle;
      io_read_strobe_o <= (nmode[3:2] == `DIR_WRITE) && rd_cycle;
      if (fifo_pop)
      begin
        mem_wvalid_o <= 1'b1;
        mem_waddr_o <= fifo_out_data[27:8];
        mem_wdata_o <= fifo_out_data[7:0];
      end
      else if (mem_wready_i)
        mem_wvalid_o <= 1'b0;
    end
  end
endmodule // dma_unit

// ===== dv/dma_unit_sva.sv
// dma_unit_sva.sv: port-level checks for the dma unit
// assumes the bus partner grants one cycle after a request
`timescale 1ns/10ps
module dma_unit_sva (
  input wire clock_i,
  input wire resetn_i,
  input wire [3:0] port_addr_i,
  input wire port_wr_i,
  input wire port_rd_i,
  input wire [7:0] port_wdata_i,
  input wire [7:0] port_rdata_o,
  input wire bus_ack_i,
  input wire bus_request_o,
  input wire [3:0] channel_ack_o,
  input wire terminal_count_o,
  input wire mem_read_strobe_o,
  input wire io_write_strobe_o,
  input wire mem_wvalid_o,
  input wire mem_wready_i,
  input wire [19:0] mem_waddr_o,
  input wire [7:0] mem_wdata_o
);
  reg dis_q;
  reg ext_q;
  // ----
  // shadow of disable and extended write, cleared by either reset
  // ----
  always @(posedge clock_i)
  begin
    if (!resetn_i || (port_wr_i && port_addr_i == 4'h0))
    begin
      dis_q <= 1'h0;
      ext_q <= 1'h0;
    end
    else if (port_wr_i && port_addr_i == 4'h8)
      dis_q <= port_wdata_i[2];
    else if (port_wr_i && port_addr_i == 4'h9)
      ext_q <= port_wdata_i[1];
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  chk_reserved_zero: assert property (
    port_rd_i && port_addr_i inside {4'h0, 4'h7, [4'hC:4'hE]} |=> port_rdata_o == 8'h00)
    else $error("reserved offset read not zero");
  chk_select_layout: assert property (
    port_rd_i && port_addr_i == 4'h1 |=> port_rdata_o[7:5] == 3'h0 && $onehot(port_rdata_o[3:0]))
    else $error("channel select read layout wrong");
  chk_upper_nibble: assert property (
    port_rd_i && port_addr_i == 4'h6 |=> port_rdata_o[7:4] == 4'h0)
    else $error("address upper bits not zero");
  chk_wait_release: assert property (
    bus_request_o && !bus_ack_i && |channel_ack_o ##1 !bus_request_o |-> channel_ack_o == 4'h0)
    else $error("channel ack kept in bus wait");
  chk_wait_gap: assert property (
    bus_request_o && !bus_ack_i && |channel_ack_o ##1 !bus_request_o
      |=> !bus_request_o ##1 bus_request_o)
    else $error("bus request gap not two clocks");
  chk_resume_grant: assert property (
    bus_request_o && bus_ack_i && channel_ack_o == 4'h0 |=> channel_ack_o != 4'h0)
    else $error("grant not followed by transfer");
  chk_disable_hold: assert property (
    dis_q && !bus_request_o |=> !bus_request_o)
    else $error("bus request while disabled");
  chk_write_timing: assert property (
    $rose(mem_read_strobe_o) |-> (io_write_strobe_o == ext_q) ##1 io_write_strobe_o)
    else $error("write strobe timing wrong");
  chk_tc_pulse: assert property (
    terminal_count_o |-> $past(channel_ack_o) != 4'h0 ##1 !terminal_count_o)
    else $error("terminal count pulse wrong");
  chk_sink_hold: assert property (
    mem_wvalid_o && !mem_wready_i |=> mem_wvalid_o && $stable({mem_waddr_o, mem_wdata_o}))
    else $error("memory write dropped while stalled");
endmodule // dma_unit_sva
bind dma_unit dma_unit_sva chk_u (
  .clock_i(clock_i), .resetn_i(resetn_i), .port_addr_i(port_addr_i),
  .port_wr_i(port_wr_i), .port_rd_i(port_rd_i), .port_wdata_i(port_wdata_i),
  .port_rdata_o(port_rdata_o), .bus_ack_i(bus_ack_i), .bus_request_o(bus_request_o),
  .channel_ack_o(channel_ack_o), .terminal_count_o(terminal_count_o),
  .mem_read_strobe_o(mem_read_strobe_o), .io_write_strobe_o(io_write_strobe_o),
  .mem_wvalid_o(mem_wvalid_o), .mem_wready_i(mem_wready_i),
  .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o)
);

// ===== dv/dma_bus_partner.sv
// dma_bus_partner.sv: bus access unit, io source and memory sink
// assumes refresh queue full is shared with the dma unit
`timescale 1ns/10ps
module dma_bus_partner (
  input wire clock_i,
  input wire resetn_i,
  input wire bus_request_i,
  input wire refresh_queue_full_i,
  input wire io_read_strobe_i,
  input wire sink_stall_i,
  output reg bus_ack_o,
  output wire mem_wready_o,
  output wire [7:0] io_data_o
);
  reg [2:0] refresh_left;
  reg [7:0] io_seq;
  reg strobe_q;
  // refresh holds the bus six cycles, longer than one transfer,
  // so the ack drop always spans a T1
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      refresh_left <= 3'h0;
      bus_ack_o <= 1'h0;
      io_seq <= 8'hA5;
      strobe_q <= 1'h0;
    end
    else
    begin
      if (refresh_queue_full_i)
        refresh_left <= 3'h6;
      else if (refresh_left != 3'h0)
        refresh_left <= refresh_left - 3'h1;
      bus_ack_o <= bus_request_i && !refresh_queue_full_i && refresh_left == 3'h0;
      strobe_q <= io_read_strobe_i;
      if (strobe_q && !io_read_strobe_i)
        io_seq <= io_seq + 8'h01;
    end
  end
  // data held one cycle past the strobe, inverted once released
  assign io_data_o = (io_read_strobe_i || strobe_q) ? io_seq : ~io_seq;
  assign mem_wready_o = !sink_stall_i;
endmodule // dma_bus_partner

// ===== dv/tb_top.sv
// tb_top.sv: self-checking bench for the dma unit
// assumes the partner model answers bus requests and sinks writes
`timescale 1ns/10ps
`include "dma_unit_map.vh"
module tb_top;
  localparam [15:0] reserved_map = 16'h7081;
  reg clock_i = 1'h0;
  reg resetn_i = 1'h0;
  reg [3:0] port_addr_i = 4'h0;
  reg port_wr_i = 1'h0;
  reg port_rd_i = 1'h0;
  reg [7:0] port_wdata_i = 8'h00;
  reg refresh_queue_full_i = 1'h0;
  reg [3:0] channel_request_i = 4'h0;
  reg ready_i = 1'h1;
  reg sink_stall = 1'h0;
  integer num_errors = 0;
  integer checks_done = 0;
  reg [27:0] got[$];
  wire bus_ack_i, bus_request_o, terminal_count_o, io_read_strobe_o, mem_wvalid_o, mem_wready_i;
  wire [3:0] channel_ack_o;
  wire [7:0] port_rdata_o, io_data_i, mem_wdata_o;
  wire [19:0] mem_addr_o, mem_waddr_o;
  dma_unit dut_u (
    .clock_i(clock_i), .resetn_i(resetn_i), .port_addr_i(port_addr_i),
    .port_wr_i(port_wr_i), .port_rd_i(port_rd_i), .port_wdata_i(port_wdata_i),
    .port_rdata_o(port_rdata_o), .refresh_queue_full_i(refresh_queue_full_i),
    .bus_ack_i(bus_ack_i), .bus_request_o(bus_request_o),
    .channel_request_i(channel_request_i), .channel_ack_o(channel_ack_o),
    .end_i(1'h0), .ready_i(ready_i), .terminal_count_o(terminal_count_o),
    .mem_addr_o(mem_addr_o), .mem_read_strobe_o(), .io_read_strobe_o(io_read_strobe_o),
    .io_write_strobe_o(), .io_data_i(io_data_i), .mem_wvalid_o(mem_wvalid_o),
    .mem_wready_i(mem_wready_i), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o)
  );
  dma_bus_partner far_u (
    .clock_i(clock_i), .resetn_i(resetn_i), .bus_request_i(bus_request_o),
    .refresh_queue_full_i(refresh_queue_full_i), .io_read_strobe_i(io_read_strobe_o),
    .sink_stall_i(sink_stall), .bus_ack_o(bus_ack_i), .mem_wready_o(mem_wready_i),
    .io_data_o(io_data_i)
  );
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i)
    if (mem_wvalid_o && mem_wready_i)
      got.push_back({mem_waddr_o, mem_wdata_o});
  // ----
  // shared tasks
  // ----
  task check(input string nm, input [27:0] seen, input [27:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        num_errors = num_errors + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(negedge clock_i);
      port_addr_i = a;
      port_wdata_i = d;
      port_wr_i = 1'h1;
      @(negedge clock_i);
      port_wr_i = 1'h0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      @(negedge clock_i);
      port_addr_i = a;
      port_rd_i = 1'h1;
      @(negedge clock_i);
      port_rd_i = 1'h0;
      check($sformatf("offset %h", a), {20'h0, port_rdata_o}, {20'h0, exp});
    end
  endtask
  task prog(input [7:0] ch, input [7:0] md, input [15:0] cnt, input [19:0] ad);
    begin
      wr(`OFS_CHSEL, ch);
      wr(`OFS_CNT_LO, cnt[7:0]);
      wr(`OFS_CNT_HI, cnt[15:8]);
      wr(`OFS_ADR_LO, ad[7:0]);
      wr(`OFS_ADR_HI, ad[15:8]);
      wr(`OFS_ADR_UP, {4'h0, ad[19:16]});
      wr(`OFS_MODE, md);
    end
  endtask
  task rdcur(input [19:0] ad, input [15:0] cnt);
    begin
      rd(`OFS_ADR_LO, ad[7:0]);
      rd(`OFS_ADR_HI, ad[15:8]);
      rd(`OFS_ADR_UP, {4'h0, ad[19:16]});
      rd(`OFS_CNT_LO, cnt[7:0]);
      rd(`OFS_CNT_HI, cnt[15:8]);
    end
  endtask
  task wait_ack;
    repeat (60) if (channel_ack_o == 4'h0) @(negedge clock_i);
  endtask
  task wait_tc;
    begin
      repeat (300) if (terminal_count_o !== 1'h1) @(negedge clock_i);
      check("terminal count", {27'h0, terminal_count_o}, 28'h1);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_defaults;
    integer i;
    begin
      rd(`OFS_CHSEL, 8'h01);
      rd(`OFS_MODE, 8'h00);
      rd(`OFS_MASK, 8'h0F);
      rd(`OFS_STATUS, 8'h00);
      for (i = 0; i < 16; i = i + 1)
        if (reserved_map[i])
        begin
          wr(i[3:0], 8'hFF);
          rd(i[3:0], 8'h00);
        end
      $display("test defaults done");
    end
  endtask
  task t_regs;
    begin
      wr(`OFS_CHSEL, 8'h02);
      rd(`OFS_CHSEL, 8'h04);
      wr(`OFS_CNT_LO, 8'h34);
      wr(`OFS_ADR_LO, 8'h9A);
      wr(`OFS_CHSEL, 8'h06);
      rd(`OFS_CHSEL, 8'h14);
      wr(`OFS_CNT_LO, 8'h77);
      wr(`OFS_ADR_LO, 8'h11);
      rd(`OFS_CNT_LO, 8'h77);
      rd(`OFS_ADR_LO, 8'h11);
      wr(`OFS_CHSEL, 8'h02);
      rd(`OFS_CNT_LO, 8'h34);
      rd(`OFS_ADR_LO, 8'h9A);
      wr(`OFS_ADR_UP, 8'hFF);
      rd(`OFS_ADR_UP, 8'h0F);
      wr(`OFS_MODE, 8'hFF);
      rd(`OFS_MODE, 8'hFD);
      wr(`OFS_CHSEL, 8'h01);
      rd(`OFS_MODE, 8'h00);
      wr(`OFS_DC_LO, 8'hFF);
      rd(`OFS_DC_LO, 8'h34);
      wr(`OFS_DC_HI, 8'hFF);
      rd(`OFS_DC_HI, 8'h03);
      wr(`OFS_STATUS, 8'hFF);
      rd(`OFS_STATUS, 8'h00);
      wr(`OFS_INIT, 8'h00);
      rd(`OFS_CHSEL, 8'h01);
      rd(`OFS_DC_LO, 8'h00);
      wr(`OFS_CHSEL, 8'h02);
      rd(`OFS_MODE, 8'h00);
      rd(`OFS_ADR_LO, 8'h00);
      $display("test registers done");
    end
  endtask
  task t_read_block;
    begin
      prog(8'h00, 8'h88, 16'h0002, 20'h12345);
      wr(`OFS_DC_HI, 8'h02);
      wr(`OFS_MASK, 8'h0E);
      channel_request_i = 4'h1;
      wait_ack;
      channel_request_i = 4'h0;
      check("ack", {24'h0, channel_ack_o}, 28'h1);
      check("address", {8'h0, mem_addr_o}, 28'h12345);
      wait_tc;
      rdcur(20'h12348, 16'hFFFF);
      rd(`OFS_STATUS, 8'h01);
      rd(`OFS_STATUS, 8'h00);
      rd(`OFS_MASK, 8'h0F);
      $display("test dma read done");
    end
  endtask
  task t_write_wait;
    integer k;
    begin
      prog(8'h01, 8'hB4, 16'h0009, 20'h00100);
      wr(`OFS_MASK, 8'h0D);
      sink_stall = 1'h1;
      channel_request_i = 4'h2;
      wait_ack;
      channel_request_i = 4'h0;
      repeat (2) @(negedge clock_i);
      refresh_queue_full_i = 1'h1;
      @(negedge clock_i);
      refresh_queue_full_i = 1'h0;
      repeat (80) @(negedge clock_i);
      check("stalled ack", {24'h0, channel_ack_o}, 28'h2);
      sink_stall = 1'h0;
      wait_tc;
      repeat (20) @(negedge clock_i);
      check("writes", got.size(), 28'hA);
      for (k = 0; k < got.size(); k = k + 1)
        check("write", got[k], {20'h00100 - k[19:0], 8'hA5 + k[7:0]});
      rdcur(20'h00100, 16'h0009);
      rd(`OFS_MASK, 8'h0D);
      rd(`OFS_STATUS, 8'h02);
      $display("test dma write done");
    end
  endtask
  task t_disable_verify;
    integer n;
    begin
      prog(8'h02, 8'h40, 16'h0000, 20'h00200);
      wr(`OFS_DC_LO, 8'h04);
      wr(`OFS_MASK, 8'h0B);
      channel_request_i = 4'h4;
      repeat (10) @(negedge clock_i);
      check("request", {27'h0, bus_request_o}, 28'h0);
      rd(`OFS_STATUS, 8'h40);
      ready_i = 1'h0;
      wr(`OFS_DC_LO, 8'h00);
      wait_ack;
      channel_request_i = 4'h0;
      n = 0;
      while (channel_ack_o != 4'h0 && n < 40)
      begin
        @(negedge clock_i);
        n = n + 1;
        if (n == 6)
          ready_i = 1'h1;
      end
      check("waited", {27'h0, n > 5}, 28'h1);
      rd(`OFS_MASK, 8'h0F);
      rd(`OFS_STATUS, 8'h04);
      $display("test disable and verify done");
    end
  endtask
  initial
  begin
    #(50 * 20000);
    num_errors = num_errors + 1;
    end_sim;
  end
  initial
  begin
    repeat (5) @(negedge clock_i);
    resetn_i = 1'h1;
    t_defaults;
    t_regs;
    t_read_block;
    t_write_wait;
    t_disable_verify;
    end_sim;
  end
endmodule // tb_top
